// [design/trc_pkg.sv]
// Notes on behaviour
// - The timer flag (control bit 7) is set on every counter overflow and, in compare mode, on every compare match.
// - A set timer flag with the timer interrupt enable and the global interrupt enable both on raises the interrupt.
// - Hardware never clears the timer flag; software clears it by writing zero.
// - Run bit 2 at 1 lets the counter count; at 0 the counter stops counting, but capture clear and capture-triggered reloads still change it.
// - Control bit 0 picks the mode: 0 is auto-reload, 1 is compare.
// - Reload enable (mode bit 7) at 1 allows copying the reload value into the counter; at 0 it blocks every reload.
// - Divider select (mode bits 6:4) divides the timer clock by 1, 4, 16, 32, 64, 128, 256 or 512 for codes 000 to 111.
// - A capture event copies the current 16-bit count into the reload/compare pair.
// - In auto-reload mode with capture clear (bit 3) at 1 the counter goes to 0000H after the capture copy.
// - In compare mode with match clear (bit 2) at 1 the counter goes to 0000H after a compare match.
// - Reload trigger select picks the reload event: 00 overflow, 01 capture 0, 10 capture 1, 11 capture 2.
// - The two reload/compare bytes form one 16-bit value, the compare value or the reload value by mode.
// - The counter is 16 bits and its low and high bytes are separate read/write registers.
package trc_pkg;

  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] TRC_IDX_CONTROL    = 8'hC8;
  localparam logic [7:0] TRC_IDX_MODE       = 8'hC9;
  localparam logic [7:0] TRC_IDX_RCMP_LOW   = 8'hCA;
  localparam logic [7:0] TRC_IDX_RCMP_HIGH  = 8'hCB;
  localparam logic [7:0] TRC_IDX_COUNT_LOW  = 8'hCC;
  localparam logic [7:0] TRC_IDX_COUNT_HIGH = 8'hCD;
  localparam logic [7:0] TRC_IDX_IRQ_ENABLE = 8'hE0;
  localparam logic [7:0] TRC_IDX_EVT_STATUS = 8'hE1;
  localparam logic [7:0] TRC_IDX_EVT_MASK   = 8'hE2;

  // ==========================================================
  // Field positions
  localparam int TRC_CTRL_FLAG_BIT     = 7;
  localparam int TRC_CTRL_RUN_BIT      = 2;
  localparam int TRC_CTRL_MODE_BIT     = 0;
  localparam int TRC_MODE_RELOAD_BIT   = 7;
  localparam int TRC_MODE_DIV_MSB      = 6;
  localparam int TRC_MODE_DIV_LSB      = 4;
  localparam int TRC_MODE_CAPCLR_BIT   = 3;
  localparam int TRC_MODE_MATCHCLR_BIT = 2;
  localparam int TRC_MODE_TRIG_MSB     = 1;
  localparam int TRC_MODE_TRIG_LSB     = 0;
  localparam int TRC_IRQ_TIMER_BIT     = 0;
  localparam int TRC_IRQ_GLOBAL_BIT    = 1;
  localparam int TRC_IRQ_EN_WIDTH      = 2;

  // ==========================================================
  // Event status bits
  localparam int TRC_EVT_OVERFLOW = 0;
  localparam int TRC_EVT_MATCH    = 1;
  localparam int TRC_EVT_CAPTURE  = 2;
  localparam int TRC_EVT_RELOAD   = 3;
  localparam int TRC_EVT_COUNT    = 4;

  // ==========================================================
  // Widths and reset values
  localparam int          TRC_COUNT_WIDTH  = 16;
  localparam int          TRC_CAP_CHANNELS = 3;
  localparam int          TRC_DIV_SEL_BITS = 3;
  localparam logic [7:0]  TRC_BYTE_RESET   = 8'h00;
  localparam logic [15:0] TRC_COUNT_RESET  = 16'h0000;
  localparam logic [15:0] TRC_COUNT_MAX    = 16'hFFFF;

  // Reload trigger codes
  typedef enum logic [1:0] {
    TRC_TRIG_OVERFLOW = 2'h0,
    TRC_TRIG_CAPTURE0 = 2'h1,
    TRC_TRIG_CAPTURE1 = 2'h2,
    TRC_TRIG_CAPTURE2 = 2'h3
  } trc_trigger_type;

  // Divider code to power-of-two shift: 1,4,16,32,64,128,256,512
  function automatic logic [3:0] trc_div_shift(input logic [2:0] sel);
    case (sel)
      3'h0:    trc_div_shift = 4'h0;
      3'h1:    trc_div_shift = 4'h2;
      3'h2:    trc_div_shift = 4'h4;
      3'h3:    trc_div_shift = 4'h5;
      3'h4:    trc_div_shift = 4'h6;
      3'h5:    trc_div_shift = 4'h7;
      3'h6:    trc_div_shift = 4'h8;
      default: trc_div_shift = 4'h9;
    endcase
  endfunction

  // Prescaler counter width needed for the largest ratio
  localparam int TRC_PRESCALE_MIN_WIDTH = 9;

endpackage

// [design/trc_prescaler.sv]
`timescale 1ns/1ps
// ==========================================================
// Timer clock divider producing a one-cycle tick
module trc_prescaler #(
  parameter int PRESCALE_WIDTH = 9
) (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset_n,
  // Control
  input  wire logic                                  runEn,
  input  wire logic [trc_pkg::TRC_DIV_SEL_BITS-1:0] divSel,
  // Tick out
  output logic                                       tick
);
  import trc_pkg::*;

  logic [PRESCALE_WIDTH-1:0] divCntQ;
  logic [PRESCALE_WIDTH-1:0] divCntD;
  logic [PRESCALE_WIDTH-1:0] divLimit;

  // Refuse a counter too narrow for the largest ratio
  if (PRESCALE_WIDTH < TRC_PRESCALE_MIN_WIDTH) begin : gWidthCheck
    $error("trc_prescaler: PRESCALE_WIDTH too small");
  end

  assign divLimit = PRESCALE_WIDTH'((1 << trc_div_shift(divSel)) - 1);

  // no ticks while halted; >= covers a ratio cut mid-count
  assign tick    = runEn & (divCntQ >= divLimit);
  assign divCntD = (!runEn || tick) ? '0 : divCntQ + 1'b1;

  // Divider count register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCntQ <= '0;
    end else begin
      divCntQ <= divCntD;
    end
  end

endmodule

// [design/trc_top.sv]
// The APB slave port was decided locally.
`timescale 1ns/1ps
// ==========================================================
// 16-bit reload/compare timer with APB register access
module trc_top #(
  parameter int ADDR_WIDTH     = 12,
  parameter int PRESCALE_WIDTH = 9
) (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset_n,
  // APB slave
  input  wire logic [ADDR_WIDTH-1:0]                 paddr,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [31:0]                           pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic [31:0]                                prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Capture event pulses from the capture logic
  input  wire logic [trc_pkg::TRC_CAP_CHANNELS-1:0] capEvent,
  // Interrupt request
  output logic                                       intReq
);
  import trc_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (ADDR_WIDTH < 11) begin : gAddrCheck
    $error("trc_top: ADDR_WIDTH must be at least 11");
  end

  // ==========================================================
  // Declarations
  logic                        flagQ;
  logic                        flagD;
  logic                        runQ;
  logic                        runD;
  logic                        cmpModeQ;
  logic                        cmpModeD;
  logic [7:0]                  modeRegQ;
  logic [7:0]                  modeRegD;
  logic [TRC_COUNT_WIDTH-1:0]  rcmpQ;
  logic [TRC_COUNT_WIDTH-1:0]  rcmpD;
  logic [TRC_COUNT_WIDTH-1:0]  countQ;
  logic [TRC_COUNT_WIDTH-1:0]  countD;
  logic [TRC_IRQ_EN_WIDTH-1:0] irqEnQ;
  logic [TRC_IRQ_EN_WIDTH-1:0] irqEnD;
  logic [TRC_EVT_COUNT-1:0]    evtStatQ;
  logic [TRC_EVT_COUNT-1:0]    evtStatD;
  logic [TRC_EVT_COUNT-1:0]    evtMaskQ;
  logic [TRC_EVT_COUNT-1:0]    evtMaskD;
  logic [TRC_EVT_COUNT-1:0]    evtSet;
  logic [TRC_EVT_COUNT-1:0]    evtClr;
  logic [31:0]                 prdataQ;
  logic [31:0]                 prdataD;
  logic                        intReqQ;
  logic                        intReqD;

  // Bus decode wires
  logic       setupPhase;
  logic       accessPhase;
  logic       wrEn;
  logic       inRange;
  logic       addrHit;
  logic [7:0] regIdx;
  logic [7:0] wByte;
  logic [7:0] readByte;
  logic       wrCtrl;
  logic       wrMode;
  logic       wrRcmpLow;
  logic       wrRcmpHigh;
  logic       wrCountLow;
  logic       wrCountHigh;
  logic       wrIrqEn;
  logic       wrStat;
  logic       wrMask;

  // Timer event wires
  logic            tick;
  logic            autoMode;
  logic            reloadEn;
  logic            capClrEn;
  logic            matchClrEn;
  logic [2:0]      divSel;
  trc_trigger_type trigSel;
  logic            overflowHit;
  logic            matchHit;
  logic            capAny;
  logic            capSelHit;
  logic            reloadHit;
  logic            capClear;
  logic            matchClear;
  logic            zeroCount;
  logic            countWrite;

  // Register index match for both decode and readback
  function automatic logic isMapped(input logic [7:0] idx);
    case (idx)
      TRC_IDX_CONTROL,
      TRC_IDX_MODE,
      TRC_IDX_RCMP_LOW,
      TRC_IDX_RCMP_HIGH,
      TRC_IDX_COUNT_LOW,
      TRC_IDX_COUNT_HIGH,
      TRC_IDX_IRQ_ENABLE,
      TRC_IDX_EVT_STATUS,
      TRC_IDX_EVT_MASK: isMapped = 1'b1;
      default:          isMapped = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // APB decode
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign regIdx      = paddr[9:2];
  assign inRange     = (paddr[ADDR_WIDTH-1:10] == '0);
  assign addrHit     = inRange & isMapped(regIdx);
  assign wrEn        = accessPhase & pwrite & pstrb[0] & inRange;
  assign wByte       = pwdata[7:0];

  // Per-register write strobes
  assign wrCtrl      = wrEn & (regIdx == TRC_IDX_CONTROL);
  assign wrMode      = wrEn & (regIdx == TRC_IDX_MODE);
  assign wrRcmpLow   = wrEn & (regIdx == TRC_IDX_RCMP_LOW);
  assign wrRcmpHigh  = wrEn & (regIdx == TRC_IDX_RCMP_HIGH);
  assign wrCountLow  = wrEn & (regIdx == TRC_IDX_COUNT_LOW);
  assign wrCountHigh = wrEn & (regIdx == TRC_IDX_COUNT_HIGH);
  assign wrIrqEn     = wrEn & (regIdx == TRC_IDX_IRQ_ENABLE);
  assign wrStat      = wrEn & (regIdx == TRC_IDX_EVT_STATUS);
  assign wrMask      = wrEn & (regIdx == TRC_IDX_EVT_MASK);

  // Zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = accessPhase & ~addrHit;
  assign prdata  = prdataQ;

  // ==========================================================
  // Read path
  always_comb begin
    readByte = TRC_BYTE_RESET;
    case (regIdx)
      TRC_IDX_CONTROL: begin
        readByte[TRC_CTRL_FLAG_BIT] = flagQ;
        readByte[TRC_CTRL_RUN_BIT]  = runQ;
        readByte[TRC_CTRL_MODE_BIT] = cmpModeQ;
      end
      TRC_IDX_MODE:       readByte = modeRegQ;
      TRC_IDX_RCMP_LOW:   readByte = rcmpQ[7:0];
      TRC_IDX_RCMP_HIGH:  readByte = rcmpQ[15:8];
      TRC_IDX_COUNT_LOW:  readByte = countQ[7:0];
      TRC_IDX_COUNT_HIGH: readByte = countQ[15:8];
      TRC_IDX_IRQ_ENABLE: readByte = {6'h00, irqEnQ};
      TRC_IDX_EVT_STATUS: readByte = {4'h0, evtStatQ};
      TRC_IDX_EVT_MASK:   readByte = {4'h0, evtMaskQ};
      default:            readByte = TRC_BYTE_RESET;
    endcase
  end

  // Read data is sampled in the setup cycle, held through access
  assign prdataD = setupPhase
                 ? (addrHit ? {24'h000000, readByte} : 32'h00000000)
                 : prdataQ;

  // Read data register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdataQ <= 32'h00000000;
    end else begin
      prdataQ <= prdataD;
    end
  end

  // ==========================================================
  // Configuration fields
  assign autoMode   = ~cmpModeQ;
  assign reloadEn   = modeRegQ[TRC_MODE_RELOAD_BIT];
  assign divSel     = modeRegQ[TRC_MODE_DIV_MSB:TRC_MODE_DIV_LSB];
  assign capClrEn   = modeRegQ[TRC_MODE_CAPCLR_BIT];
  assign matchClrEn = modeRegQ[TRC_MODE_MATCHCLR_BIT];
  assign trigSel    = trc_trigger_type'(modeRegQ[TRC_MODE_TRIG_MSB:TRC_MODE_TRIG_LSB]);

  trc_prescaler #(
    .PRESCALE_WIDTH (PRESCALE_WIDTH)
  ) uPrescaler (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .runEn   (runQ),
    .divSel  (divSel),
    .tick    (tick)
  );

  // ==========================================================
  // Timer events
  // overflow on the tick that leaves FFFFH
  assign overflowHit = tick & (countQ == TRC_COUNT_MAX);
  // compare match on a tick taken while the counter equals the compare value
  assign matchHit    = tick & cmpModeQ & (countQ == rcmpQ);
  assign capAny      = |capEvent;

  // capture channel chosen by the trigger code
  always_comb begin
    case (trigSel)
      TRC_TRIG_CAPTURE0: capSelHit = capEvent[0];
      TRC_TRIG_CAPTURE1: capSelHit = capEvent[1];
      TRC_TRIG_CAPTURE2: capSelHit = capEvent[2];
      default:           capSelHit = 1'b0;
    endcase
  end

  // reloads only with reload enable, in auto-reload mode
  assign reloadHit = reloadEn & autoMode
                   & ((trigSel == TRC_TRIG_OVERFLOW) ? overflowHit : capSelHit);

  // capture clear only in auto-reload mode
  assign capClear   = capAny & autoMode & capClrEn;
  // match clear only in compare mode
  assign matchClear = matchHit & matchClrEn;
  assign zeroCount  = capClear | matchClear;
  assign countWrite = wrCountLow | wrCountHigh;

  // ==========================================================
  // Counter next value: software write, clear, reload, count
  always_comb begin
    countD = countQ;
    if (countWrite) begin
      // byte writes land on their own half
      if (wrCountLow) begin
        countD[7:0] = wByte;
      end
      if (wrCountHigh) begin
        countD[15:8] = wByte;
      end
    end else if (zeroCount) begin
      countD = TRC_COUNT_RESET;
    end else if (reloadHit) begin
      countD = rcmpQ;
    end else if (tick) begin
      countD = countQ + 16'h0001;
    end
  end

  // Counter register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      countQ <= TRC_COUNT_RESET;
    end else begin
      countQ <= countD;
    end
  end

  // ==========================================================
  // Reload/compare pair
  always_comb begin
    rcmpD = rcmpQ;
    if (capAny) begin
      rcmpD = countQ;
    end else begin
      if (wrRcmpLow) begin
        rcmpD[7:0] = wByte;
      end
      if (wrRcmpHigh) begin
        rcmpD[15:8] = wByte;
      end
    end
  end

  // Reload/compare register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rcmpQ <= TRC_COUNT_RESET;
    end else begin
      rcmpQ <= rcmpD;
    end
  end

  // ==========================================================
  // Control register
  // hardware set wins over a write
  // only a software write clears the flag
  assign flagD    = (overflowHit | matchHit) ? 1'b1
                  : (wrCtrl ? wByte[TRC_CTRL_FLAG_BIT] : flagQ);
  assign runD     = wrCtrl ? wByte[TRC_CTRL_RUN_BIT] : runQ;
  assign cmpModeD = wrCtrl ? wByte[TRC_CTRL_MODE_BIT] : cmpModeQ;
  assign modeRegD = wrMode ? wByte : modeRegQ;

  // Control and mode registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      flagQ    <= 1'b0;
      runQ     <= 1'b0;
      cmpModeQ <= 1'b0;
      modeRegQ <= TRC_BYTE_RESET;
    end else begin
      flagQ    <= flagD;
      runQ     <= runD;
      cmpModeQ <= cmpModeD;
      modeRegQ <= modeRegD;
    end
  end

  // ==========================================================
  // Interrupt status, mask and enables
  always_comb begin
    evtSet                   = '0;
    evtSet[TRC_EVT_OVERFLOW] = overflowHit;
    evtSet[TRC_EVT_MATCH]    = matchHit;
    evtSet[TRC_EVT_CAPTURE]  = capAny;
    evtSet[TRC_EVT_RELOAD]   = reloadHit;
  end

  // Write one to clear; a new event in the same cycle stays set
  assign evtClr   = wrStat ? wByte[TRC_EVT_COUNT-1:0] : '0;
  assign evtStatD = evtSet | (evtStatQ & ~evtClr);
  assign evtMaskD = wrMask ? wByte[TRC_EVT_COUNT-1:0] : evtMaskQ;
  assign irqEnD   = wrIrqEn ? wByte[TRC_IRQ_EN_WIDTH-1:0] : irqEnQ;

  // flag with both enables, or any unmasked event, under global enable
  assign intReqD = irqEnQ[TRC_IRQ_GLOBAL_BIT]
                 & ((flagQ & irqEnQ[TRC_IRQ_TIMER_BIT]) | (|(evtStatQ & evtMaskQ)));

  // Interrupt registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      evtStatQ <= '0;
      evtMaskQ <= '0;
      irqEnQ   <= '0;
      intReqQ  <= 1'b0;
    end else begin
      evtStatQ <= evtStatD;
      evtMaskQ <= evtMaskD;
      irqEnQ   <= irqEnD;
      intReqQ  <= intReqD;
    end
  end

  assign intReq = intReqQ;

endmodule

// [test/tb_top.sv]
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the reload/compare timer
module tb_top;
  import trc_pkg::*;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
    logic       err;
  } trc_row_type;

  // ==========================================================
  // Signals and bookkeeping
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [2:0]  capEvent = 3'h0;
  logic        intReq;
  logic [31:0] rdData;
  logic        rdErr;
  logic [7:0]  ctlSeen;
  logic [15:0] wordVal;
  int          miscompares = 0;
  int          nTests = 0;
  int          divN [8] = '{1, 4, 16, 32, 64, 128, 256, 512};
  trc_row_type rows [10] = '{
    '{8'hC9, 8'hFF, 8'hFF, 1'b0}, '{8'hCA, 8'hA5, 8'hA5, 1'b0}, '{8'hCB, 8'h5A, 8'h5A, 1'b0},
    '{8'hCC, 8'h3C, 8'h3C, 1'b0}, '{8'hCD, 8'hC3, 8'hC3, 1'b0}, '{8'hC8, 8'h7B, 8'h01, 1'b0},
    '{8'hE2, 8'hFF, 8'h0F, 1'b0}, '{8'hE0, 8'hFF, 8'h03, 1'b0}, '{8'hE1, 8'hFF, 8'h00, 1'b0},
    '{8'h04, 8'hFF, 8'h00, 1'b1}};

  trc_top trc_top_inst (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .paddr    (paddr),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .pwdata   (pwdata),
    .pstrb    (pstrb),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .capEvent (capEvent),
    .intReq   (intReq)
  );

  // Clock at 100 MHz
  always #5 ref_clk = ~ref_clk;

  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= 32'(wd);
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdData = prdata;
    rdErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Read a byte pair from the low index
  task automatic readWord(input logic [7:0] idx);
    apb(1'b0, idx, 8'h00);
    wordVal[7:0] = rdData[7:0];
    apb(1'b0, idx + 8'h01, 8'h00);
    wordVal[15:8] = rdData[7:0];
  endtask

  task automatic setCount(input logic [15:0] v);
    apb(1'b1, TRC_IDX_COUNT_LOW, v[7:0]);
    apb(1'b1, TRC_IDX_COUNT_HIGH, v[15:8]);
  endtask

  // Stop counting, keep the flag
  task automatic halt();
    apb(1'b0, TRC_IDX_CONTROL, 8'h00);
    ctlSeen = rdData[7:0];
    apb(1'b1, TRC_IDX_CONTROL, ctlSeen & 8'hFB);
  endtask

  task automatic irqIs(input logic exp);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check("intReq", 32'(exp), 32'(intReq));
    @(posedge ref_clk);
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    // Reset values, write, read back, refusal
    foreach (rows[i]) begin
      apb(1'b0, rows[i].idx, 8'h00);
      check("reset value", 32'h0, rdData);
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 8'h00);
      check("read back", 32'(rows[i].rd), rdData);
      check("slave error", 32'(rows[i].err), 32'(rdErr));
    end
    pstrb <= 4'h0;
    apb(1'b1, TRC_IDX_RCMP_LOW, 8'h11);
    pstrb <= 4'hF;
    apb(1'b0, TRC_IDX_RCMP_LOW, 8'h00);
    check("masked write", 32'hA5, rdData);
    apb(1'b1, TRC_IDX_EVT_MASK, 8'h00);
    // Overflow with and without reload enable
    for (int en = 0; en < 2; en++) begin
      apb(1'b1, TRC_IDX_CONTROL, 8'h00);
      apb(1'b1, TRC_IDX_MODE, en ? 8'h80 : 8'h00);
      apb(1'b1, TRC_IDX_RCMP_LOW, 8'h34);
      apb(1'b1, TRC_IDX_RCMP_HIGH, 8'h12);
      setCount(16'hFFFE);
      apb(1'b1, TRC_IDX_CONTROL, 8'h04);
      irqIs(1'b1);
      halt();
      check("flag after overflow", 32'h84, 32'(ctlSeen));
      readWord(TRC_IDX_COUNT_LOW);
      check("count high after wrap", en ? 32'h12 : 32'h0, 32'(wordVal[15:8]));
      repeat (30) @(posedge ref_clk);
      for (int g = 1; g < 4; g++) begin
        apb(1'b1, TRC_IDX_IRQ_ENABLE, 8'(g));
        irqIs(g == 3);
      end
      apb(1'b1, TRC_IDX_CONTROL, 8'h00);
      irqIs(1'b0);
    end
    setCount(16'h4321);
    repeat (50) @(posedge ref_clk);
    readWord(TRC_IDX_COUNT_LOW);
    check("halted count", 32'h4321, 32'(wordVal));
    // Every divider code
    for (int d = 0; d < 8; d++) begin
      apb(1'b1, TRC_IDX_MODE, {1'b0, 3'(d), 4'h0});
      setCount(16'h0000);
      apb(1'b1, TRC_IDX_CONTROL, 8'h04);
      repeat (10 * divN[d]) @(posedge ref_clk);
      halt();
      readWord(TRC_IDX_COUNT_LOW);
      check("divided ticks", 32'h1, 32'(wordVal >= 16'd10
        && int'(wordVal) * divN[d] <= 10 * divN[d] + 7));
    end
    // Compare with match clear, without it, and reload mode
    apb(1'b1, TRC_IDX_RCMP_LOW, 8'h10);
    apb(1'b1, TRC_IDX_RCMP_HIGH, 8'h00);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, TRC_IDX_CONTROL, 8'h00);
      apb(1'b1, TRC_IDX_MODE, k != 1 ? 8'h04 : 8'h00);
      setCount(16'h0000);
      apb(1'b1, TRC_IDX_CONTROL, k < 2 ? 8'h05 : 8'h04);
      repeat (40) @(posedge ref_clk);
      halt();
      check("match flag", 32'(k < 2), 32'(ctlSeen[7]));
      readWord(TRC_IDX_COUNT_LOW);
      check("past compare", 32'(k != 0), 32'(wordVal > 16'h0010));
    end
    // Capture on each channel
    apb(1'b1, TRC_IDX_EVT_STATUS, 8'h0F);
    for (int ch = 0; ch < 3; ch++) begin
      apb(1'b1, TRC_IDX_CONTROL, ch == 2 ? 8'h01 : 8'h00);
      apb(1'b1, TRC_IDX_MODE, ch == 1 ? 8'h82 : 8'h08);
      setCount(16'h0AB0 + 16'(ch));
      capEvent <= 3'(1 << ch);
      @(posedge ref_clk);
      capEvent <= 3'h0;
      @(posedge ref_clk);
      readWord(TRC_IDX_RCMP_LOW);
      check("captured pair", 32'h0AB0 + ch, 32'(wordVal));
      readWord(TRC_IDX_COUNT_LOW);
      check("capture count", ch == 2 ? 32'hAB2 : 32'(ch) * 32'hAB0, 32'(wordVal));
    end
    apb(1'b1, TRC_IDX_CONTROL, 8'h00);
    apb(1'b1, TRC_IDX_IRQ_ENABLE, 8'h02);
    apb(1'b0, TRC_IDX_EVT_STATUS, 8'h00);
    check("capture status", 32'h0C, rdData);
    apb(1'b1, TRC_IDX_EVT_MASK, 8'h04);
    irqIs(1'b1);
    apb(1'b1, TRC_IDX_EVT_MASK, 8'h00);
    irqIs(1'b0);
    apb(1'b1, TRC_IDX_EVT_MASK, 8'h04);
    irqIs(1'b1);
    apb(1'b1, TRC_IDX_EVT_STATUS, 8'h04);
    irqIs(1'b0);
    // Reset while running
    setCount(16'h5A5A);
    apb(1'b1, TRC_IDX_CONTROL, 8'h05);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    readWord(TRC_IDX_COUNT_LOW);
    check("count after reset", 32'h0, 32'(wordVal));
    apb(1'b0, TRC_IDX_CONTROL, 8'h00);
    check("control after reset", 32'h0, rdData);
    give_verdict();
  end
endmodule

// [test/trc_checker_sva.sv]
`timescale 1ns/1ps
// ==========================================================
// Port-level checker for the reload/compare timer
module trc_checker_sva #(
  parameter int ADDR_WIDTH = 12
) (
  // Clock and reset
  input  wire logic                                  ref_clk,
  input  wire logic                                  reset_n,
  // APB slave
  input  wire logic [ADDR_WIDTH-1:0]                 paddr,
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [31:0]                           pwdata,
  input  wire logic [3:0]                            pstrb,
  input  wire logic [31:0]                           prdata,
  input  wire logic                                  pready,
  input  wire logic                                  pslverr,
  // Capture and interrupt
  input  wire logic [trc_pkg::TRC_CAP_CHANNELS-1:0] capEvent,
  input  wire logic                                  intReq
);
  import trc_pkg::*;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ==========================================================
  // Address decode and completed transfers
  wire logic [7:0] regIdx   = paddr[9:2];
  wire logic       accessPh = psel && penable;
  wire logic       regHit   = (paddr[1:0] == 2'h0) && (paddr[ADDR_WIDTH-1:10] == '0)
    && ((regIdx >= TRC_IDX_CONTROL && regIdx <= TRC_IDX_COUNT_HIGH)
    || (regIdx >= TRC_IDX_IRQ_ENABLE && regIdx <= TRC_IDX_EVT_MASK));
  wire logic       badAddr  = (paddr[1:0] == 2'h0) && !regHit;
  wire logic       wrDone   = accessPh && pwrite && pstrb[0] && regHit;
  wire logic       ctlWr    = wrDone && (regIdx == TRC_IDX_CONTROL);
  wire logic       lowWr    = wrDone && (regIdx == TRC_IDX_COUNT_LOW);
  wire logic       rdLowAcc = accessPh && !pwrite && regHit && (regIdx == TRC_IDX_COUNT_LOW);

  // ==========================================================
  // Shadows of run, global enable and count low byte
  logic       runSh_q;
  logic       globSh_q;
  logic       lowValid_q;
  logic [7:0] lowSeen_q;
  wire logic       runD      = ctlWr ? pwdata[TRC_CTRL_RUN_BIT] : runSh_q;
  wire logic       lowValidD = (lowValid_q || rdLowAcc || lowWr) && !runD && !runSh_q
    && (capEvent == '0);
  wire logic [7:0] lowSeenD  = lowWr ? pwdata[7:0] : (rdLowAcc ? prdata[7:0] : lowSeen_q);
  wire logic       globD     = (wrDone && (regIdx == TRC_IDX_IRQ_ENABLE))
    ? pwdata[TRC_IRQ_GLOBAL_BIT] : globSh_q;

  // Shadow registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      runSh_q    <= 1'b0;
      globSh_q   <= 1'b0;
      lowValid_q <= 1'b0;
      lowSeen_q  <= 8'h00;
    end else begin
      runSh_q    <= runD;
      globSh_q   <= globD;
      lowValid_q <= lowValidD;
      lowSeen_q  <= lowSeenD;
    end
  end

  // ==========================================================
  // Assertions
  a_halt_hold: assert property (rdLowAcc && lowValid_q |-> prdata[7:0] == lowSeen_q)
    else $error("count low byte moved while halted");
  a_glob_quiet: assert property ((!globSh_q) [*2] |-> !intReq)
    else $error("interrupt raised with global enable off");
  a_irq_held: assert property (intReq && !wrDone && !$past(wrDone) |=> intReq)
    else $error("interrupt dropped without a write");
  a_unmapped_err: assert property (accessPh && badAddr |-> pslverr)
    else $error("no slave error on unmapped address");
  a_unmapped_zero: assert property (accessPh && badAddr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_err_phase: assert property (pslverr |-> accessPh && !regHit)
    else $error("slave error outside an unmapped access");
  a_byte_read: assert property (accessPh && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  a_ready_high: assert property (accessPh |-> pready && $stable(paddr))
    else $error("access phase not completed at once");
endmodule

bind trc_top trc_checker_sva #(.ADDR_WIDTH (ADDR_WIDTH)) trc_checker_sva_inst (
  .ref_clk  (ref_clk),
  .reset_n  (reset_n),
  .paddr    (paddr),
  .psel     (psel),
  .penable  (penable),
  .pwrite   (pwrite),
  .pwdata   (pwdata),
  .pstrb    (pstrb),
  .prdata   (prdata),
  .pready   (pready),
  .pslverr  (pslverr),
  .capEvent (capEvent),
  .intReq   (intReq)
);
